/* File: hdl/spv_top.sv */
// speed-dependent pwm output: two controllers, eight interpolation tables, four channels
`timescale 1ns/100ps
module spv_top import spv_pkg::*; #(
  parameter int unsigned FB_TICK = FB_TICK_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  // axis velocities
  input wire logic signed [VEL_W-1:0] cmd_vel [NUM_AXIS],
  input wire logic signed [VEL_W-1:0] fb_vel [NUM_AXIS],
  // laser pwm channels
  output logic [NUM_CH-1:0] pwm_out
);
  logic [NUM_CTL-1:0] run_q;
  logic [TSEL_W-1:0] csel_q [NUM_CTL];
  logic [NUM_CH-1:0] cmap_q [NUM_CTL];
  logic [1:0] otype_q [NUM_TBL];
  logic itype_q [NUM_TBL];
  logic filt_q [NUM_TBL];
  logic [NPTS_W-1:0] npts_q [NUM_TBL];
  logic [DATA_W-1:0] fix_q [NUM_TBL];
  logic [NUM_AXIS-1:0] src_q [NUM_TBL];
  logic [SPD_W-1:0] spd_q [NUM_TBL][NUM_PTS];
  logic [PWR_W-1:0] pwr_q [NUM_TBL][NUM_PTS];
  logic signed [VEL_W-1:0] fb_q [NUM_AXIS];
  logic signed [VEL_W-1:0] cmd_f_q [NUM_AXIS];
  logic signed [VEL_W-1:0] fb_f_q [NUM_AXIS];
  logic [CNT_W-1:0] tick_q;
  logic [SPD_W-1:0] speed_q [NUM_CTL];
  logic [PWR_W-1:0] power_q [NUM_CTL];
  logic [CNT_W-1:0] per_q [NUM_CTL];
  logic [CNT_W-1:0] hi_q [NUM_CTL];
  logic [NUM_CH-1:0] pwm_q;
  logic [DATA_W-1:0] rd_q;
  logic [DATA_W-1:0] rd_d;

  function automatic logic [VEL_W-1:0] vabs(input logic signed [VEL_W-1:0] v);
    return v[VEL_W-1] ? VEL_W'(-v) : VEL_W'(v);
  endfunction

  function automatic logic signed [VEL_W-1:0] fstep(input logic signed [VEL_W-1:0] f,
                                                    input logic signed [VEL_W-1:0] x);
    logic signed [VEL_W:0] d;
    d = {x[VEL_W-1], x} - {f[VEL_W-1], f};
    return VEL_W'(f + VEL_W'(d >>> FILT_SH));
  endfunction

  function automatic logic [SPD_W-1:0] isqrt(input logic [SQ_W-1:0] x);
    logic [SPD_W-1:0] r;
    logic [SPD_W-1:0] t;
    r = '0;
    for (int i = SPD_W - 1; i >= 0; i--) begin
      t = r | (SPD_W'(1) << i);
      if (SQ_W'(t) * SQ_W'(t) <= x) r = t;
    end
    return r;
  endfunction

  function automatic logic [CNT_W-1:0] clampu(input logic [CNT_W-1:0] x,
                                              input logic [CNT_W-1:0] lo, input logic [CNT_W-1:0] hi);
    return (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction

  // squared magnitude of the selected axes
  function automatic logic [SQ_W-1:0] sumsq(input logic [NUM_AXIS-1:0] mask, input logic use_cmd,
                                            input logic use_filt);
    logic [SQ_W-1:0] acc;
    logic [VEL_W-1:0] m;
    acc = '0;
    for (int a = 0; a < NUM_AXIS; a++) begin
      m = use_cmd ? vabs(use_filt ? cmd_f_q[a] : cmd_vel[a]) : vabs(use_filt ? fb_f_q[a] : fb_q[a]);
      if (mask[a]) acc = acc + SQ_W'(m) * SQ_W'(m);
    end
    return acc;
  endfunction

  // table points are taken as ascending in speed
  function automatic logic [PWR_W-1:0] interp(input logic [TSEL_W-1:0] t, input logic [NPTS_W-1:0] n,
                                              input logic [SPD_W-1:0] v);
    logic [IDX_W-1:0] k;
    logic [SPD_W-1:0] v0;
    logic [SPD_W-1:0] v1;
    logic [PWR_W-1:0] p0;
    logic [PWR_W-1:0] p1;
    logic [PWR_W+SPD_W-1:0] m;
    k = '0;
    for (int i = 1; i < NUM_PTS; i++) begin
      if (NPTS_W'(i) < n && spd_q[t][i] <= v) k = IDX_W'(i);
    end
    if (n <= NPTS_W'(1) || v <= spd_q[t][0]) return pwr_q[t][0];
    if (NPTS_W'(k) == n - NPTS_W'(1)) return pwr_q[t][k];
    v0 = spd_q[t][k];
    v1 = spd_q[t][k + IDX_W'(1)];
    p0 = pwr_q[t][k];
    p1 = pwr_q[t][k + IDX_W'(1)];
    if (v1 <= v0) return p0;
    if (p1 >= p0) begin
      m = (PWR_W + SPD_W)'(p1 - p0) * (PWR_W + SPD_W)'(v - v0) / (PWR_W + SPD_W)'(v1 - v0);
      return p0 + PWR_W'(m);
    end
    m = (PWR_W + SPD_W)'(p0 - p1) * (PWR_W + SPD_W)'(v - v0) / (PWR_W + SPD_W)'(v1 - v0);
    return p0 - PWR_W'(m);
  endfunction

  // period and high time in clocks; above CLK_HZ the waveform saturates to one clock
  function automatic logic [2*CNT_W-1:0] calc(input logic [1:0] ot, input logic [DATA_W-1:0] fix,
                                             input logic [PWR_W-1:0] pw);
    logic [CNT_W-1:0] per;
    logic [CNT_W-1:0] hi;
    logic [CNT_W-1:0] ns;
    logic [2*CNT_W-1:0] prod;
    per = 32'h0000_0001;
    hi = '0;
    prod = '0;
    ns = '0;
    case (ot)
      SPV_OUT_DUTY: begin
        per = CLK_HZ / clampu(fix, FREQ_MIN, FREQ_MAX);
        prod = (2*CNT_W)'(per) * (2*CNT_W)'(clampu(CNT_W'(pw), '0, DUTY_FULL));
        hi = CNT_W'(prod / (2*CNT_W)'(DUTY_FULL));
      end
      SPV_OUT_FREQ_W: begin
        ns = clampu(fix, WIDTH_MIN_NS, WIDTH_MAX_NS);
        hi = (ns + CLK_NS - 32'h0000_0001) / CLK_NS;
        per = CLK_HZ / clampu(CNT_W'(pw), FREQ_MIN, FREQ_MAX);
      end
      SPV_OUT_FREQ_D: begin
        per = CLK_HZ / clampu(CNT_W'(pw), FREQ_MIN, FREQ_MAX);
        prod = (2*CNT_W)'(per) * (2*CNT_W)'(clampu(fix, DUTY_MIN, DUTY_FULL));
        hi = CNT_W'(prod / (2*CNT_W)'(DUTY_FULL));
      end
      default: begin
        per = 32'h0000_0001;
        hi = '0;
      end
    endcase
    if (per == '0) per = 32'h0000_0001;
    return {per, hi};
  endfunction

  // address decode
  wire word_ok = (addr[1:0] == 2'h0);
  wire hit_ctrl = (addr == OFS_CTRL);
  wire hit_cfg0 = (addr == OFS_CFG0);
  wire hit_cfg1 = (addr == OFS_CFG1);
  wire hit_pw0 = (addr == OFS_POWER0);
  wire hit_pw1 = (addr == OFS_POWER1);
  wire hit_tbl = word_ok && (addr[ADDR_W-1:7] == TBL_PAGE);
  wire [TSEL_W-1:0] t_sel = addr[6:4];
  wire [1:0] t_word = addr[3:2];
  wire hit_mem = word_ok && addr[MEM_BIT];
  wire [TSEL_W-1:0] m_tbl = addr[10:8];
  wire [IDX_W-1:0] m_idx = addr[7:3];
  wire m_pwr = addr[2];
  wire fb_tick = (tick_q == FB_TICK - 1);

  // control and table registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_q <= '0;
      for (int c = 0; c < NUM_CTL; c++) begin
        csel_q[c] <= '0;
        cmap_q[c] <= '0;
      end
      for (int t = 0; t < NUM_TBL; t++) begin
        otype_q[t] <= RST_OUT_TYPE;
        itype_q[t] <= 1'b0;
        filt_q[t] <= 1'b0;
        npts_q[t] <= RST_NPTS;
        fix_q[t] <= RST_FIX;
        src_q[t] <= RST_SRC;
        for (int i = 0; i < NUM_PTS; i++) begin
          spd_q[t][i] <= '0;
          pwr_q[t][i] <= '0;
        end
      end
    end else if (wr_en) begin
      if (hit_ctrl) begin
        // start wins over stop in the same write
        run_q <= (run_q & ~wr_data[CTRL_STOP_LSB +: NUM_CTL]) | wr_data[NUM_CTL-1:0];
      end else if (hit_cfg0 || hit_cfg1) begin
        csel_q[hit_cfg1] <= wr_data[TSEL_W-1:0];
        cmap_q[hit_cfg1] <= wr_data[CFG_MAP_LSB +: NUM_CH];
      end else if (hit_tbl && t_word == TBL_W_MODE) begin
        otype_q[t_sel] <= wr_data[1:0];
        itype_q[t_sel] <= wr_data[MODE_IN_BIT];
        filt_q[t_sel] <= wr_data[MODE_FILT_BIT];
        npts_q[t_sel] <= (wr_data[MODE_NPTS_LSB +: NPTS_W] > NPTS_W'(NUM_PTS)) ?
                         NPTS_W'(NUM_PTS) : wr_data[MODE_NPTS_LSB +: NPTS_W];
      end else if (hit_tbl && t_word == TBL_W_FIX) begin
        fix_q[t_sel] <= wr_data;
      end else if (hit_tbl && t_word == TBL_W_SRC) begin
        src_q[t_sel] <= wr_data[NUM_AXIS-1:0];
      end else if (hit_mem && m_pwr) begin
        pwr_q[m_tbl][m_idx] <= wr_data[PWR_W-1:0];
      end else if (hit_mem) begin
        spd_q[m_tbl][m_idx] <= wr_data[SPD_W-1:0];
      end
    end
  end

  // velocity sampling and noise filters
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_q <= '0;
      for (int a = 0; a < NUM_AXIS; a++) begin
        fb_q[a] <= '0;
        cmd_f_q[a] <= '0;
        fb_f_q[a] <= '0;
      end
    end else begin
      tick_q <= fb_tick ? '0 : tick_q + 32'h0000_0001;
      for (int a = 0; a < NUM_AXIS; a++) begin
        cmd_f_q[a] <= fstep(cmd_f_q[a], cmd_vel[a]);
        if (fb_tick) begin
          fb_q[a] <= fb_vel[a];
          fb_f_q[a] <= fstep(fb_f_q[a], fb_vel[a]);
        end
      end
    end
  end

  // per-controller speed, power and timing pipeline
  spv_pwm_if #(.CW(CNT_W)) pif [NUM_CTL] ();

  for (genvar c = 0; c < NUM_CTL; c++) begin : g_ctl
    wire [TSEL_W-1:0] tsel = csel_q[c];
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        speed_q[c] <= '0;
        power_q[c] <= '0;
        per_q[c] <= 32'h0000_0001;
        hi_q[c] <= '0;
      end else begin
        speed_q[c] <= isqrt(sumsq(src_q[tsel], itype_q[tsel], filt_q[tsel]));
        power_q[c] <= interp(tsel, npts_q[tsel], speed_q[c]);
        {per_q[c], hi_q[c]} <= calc(otype_q[tsel], fix_q[tsel], power_q[c]);
      end
    end
    assign pif[c].run = run_q[c];
    assign pif[c].period = per_q[c];
    assign pif[c].high = hi_q[c];
    spv_pwm_gen u_gen (
      .ref_clk(ref_clk),
      .rst(rst),
      .p(pif[c])
    );
  end

  // channel routing; controller 0 has priority where both map a channel
  wire [NUM_CH-1:0] pwm_d = (cmap_q[0] & {NUM_CH{pif[0].pwm}}) |
                            (cmap_q[1] & ~cmap_q[0] & {NUM_CH{pif[1].pwm}});

  // read mux
  always_comb begin
    rd_d = '0;
    if (hit_ctrl) begin
      rd_d = DATA_W'(run_q);
    end else if (hit_cfg0 || hit_cfg1) begin
      rd_d = DATA_W'({cmap_q[hit_cfg1], 1'b0, csel_q[hit_cfg1]});
    end else if (hit_pw0) begin
      rd_d = DATA_W'(power_q[0]);
    end else if (hit_pw1) begin
      rd_d = DATA_W'(power_q[1]);
    end else if (hit_tbl && t_word == TBL_W_MODE) begin
      rd_d = DATA_W'({npts_q[t_sel], 2'h0, filt_q[t_sel], itype_q[t_sel], 2'h0, otype_q[t_sel]});
    end else if (hit_tbl && t_word == TBL_W_FIX) begin
      rd_d = fix_q[t_sel];
    end else if (hit_tbl && t_word == TBL_W_SRC) begin
      rd_d = DATA_W'(src_q[t_sel]);
    end else if (hit_mem && m_pwr) begin
      rd_d = DATA_W'(pwr_q[m_tbl][m_idx]);
    end else if (hit_mem) begin
      rd_d = DATA_W'(spd_q[m_tbl][m_idx]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_q <= '0;
      pwm_q <= '0;
    end else begin
      rd_q <= rd_en ? rd_d : '0;
      pwm_q <= pwm_d;
    end
  end

  assign rd_data = rd_q;
  assign pwm_out = pwm_q;
endmodule

/* File: hdl/spv_pkg.sv */
// shared constants, register map and mode encodings for the speed-dependent pwm block
package spv_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned FB_REFRESH_HZ = 1000;
  localparam int unsigned FB_TICK_CYC = CLK_HZ / FB_REFRESH_HZ;

  localparam int NUM_CTL = 2;
  localparam int NUM_TBL = 8;
  localparam int NUM_PTS = 32;
  localparam int NUM_CH = 4;
  localparam int NUM_AXIS = 4;
  localparam int VEL_W = 16;
  localparam int SPD_W = 17;
  localparam int SQ_W = 34;
  localparam int PWR_W = 26;
  localparam int CNT_W = 32;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int TSEL_W = 3;
  localparam int IDX_W = 5;
  localparam int NPTS_W = 6;
  localparam int FILT_SH = 2;

  typedef enum logic [1:0] {
    SPV_OUT_DUTY = 2'h1,
    SPV_OUT_FREQ_W = 2'h2,
    SPV_OUT_FREQ_D = 2'h3
  } spv_out_t;

  localparam logic [CNT_W-1:0] DUTY_FULL = 32'h0000_07D0;
  localparam logic [CNT_W-1:0] DUTY_MIN = 32'h0000_0001;
  localparam logic [CNT_W-1:0] FREQ_MIN = 32'h0000_0003;
  localparam logic [CNT_W-1:0] FREQ_MAX = 32'h02FA_F080;
  localparam logic [CNT_W-1:0] WIDTH_MIN_NS = 32'h0000_0014;
  localparam logic [CNT_W-1:0] WIDTH_MAX_NS = 32'h1400_0000;

  // register map, byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CFG0 = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CFG1 = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_POWER0 = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_POWER1 = 12'h010;
  localparam logic [4:0] TBL_PAGE = 5'h02;
  localparam logic [1:0] TBL_W_MODE = 2'h0;
  localparam logic [1:0] TBL_W_FIX = 2'h1;
  localparam logic [1:0] TBL_W_SRC = 2'h2;
  localparam int MEM_BIT = 11;

  // field positions
  localparam int CTRL_STOP_LSB = 2;
  localparam int CFG_MAP_LSB = 4;
  localparam int MODE_IN_BIT = 4;
  localparam int MODE_FILT_BIT = 5;
  localparam int MODE_NPTS_LSB = 8;

  // reset values
  localparam logic [1:0] RST_OUT_TYPE = 2'h1;
  localparam logic [NPTS_W-1:0] RST_NPTS = 6'h01;
  localparam logic [DATA_W-1:0] RST_FIX = 32'h0000_0064;
  localparam logic [NUM_AXIS-1:0] RST_SRC = 4'h1;
endpackage

/* File: hdl/spv_pwm_if.sv */
// timing words and waveform between a controller and its pwm generator
`timescale 1ns/100ps
interface spv_pwm_if #(parameter int CW = 32);
  logic run;
  logic [CW-1:0] period;
  logic [CW-1:0] high;
  logic pwm;
  modport gen (input run, input period, input high, output pwm);
  modport ctl (output run, output period, output high, input pwm);
endinterface

/* File: hdl/spv_pwm_gen.sv */
// one pwm waveform generator, new timing taken only at a period boundary
`timescale 1ns/100ps
module spv_pwm_gen import spv_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // timing and waveform
  spv_pwm_if.gen p
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] per_q;
  logic [CNT_W-1:0] hi_q;
  logic pwm_q;
  wire wrap = (cnt_q + 32'h0000_0001 >= per_q);

  // latching at the wrap avoids runt pulses when the table value moves
  always_ff @(posedge ref_clk) begin
    if (rst || !p.run) begin
      cnt_q <= '0;
      per_q <= 32'h0000_0001;
      hi_q <= '0;
      pwm_q <= 1'b0;
    end else begin
      cnt_q <= wrap ? '0 : cnt_q + 32'h0000_0001;
      if (wrap) begin
        per_q <= p.period;
        hi_q <= p.high;
      end
      pwm_q <= wrap ? (p.high != '0) : (cnt_q + 32'h0000_0001 < hi_q);
    end
  end

  assign p.pwm = pwm_q;
endmodule

/* File: tb/spv_top_properties.sv */
// port-level assertions for the speed-dependent pwm block
`timescale 1ns/100ps
module spv_top_properties import spv_pkg::*; #(
  parameter int unsigned FB_TICK = FB_TICK_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  // laser pwm channels
  input wire logic [NUM_CH-1:0] pwm_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [1:0] run_q;
  logic [3:0] map0_q;
  logic [3:0] map1_q;
  wire ctrl_wr = wr_en && addr == OFS_CTRL;
  // mirror of run state and channel maps; start wins over stop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_q <= 2'h0;
      map0_q <= 4'h0;
      map1_q <= 4'h0;
    end else begin
      if (ctrl_wr) run_q <= (run_q & ~wr_data[3:2]) | wr_data[1:0];
      if (wr_en && addr == OFS_CFG0) map0_q <= wr_data[7:4];
      if (wr_en && addr == OFS_CFG1) map1_q <= wr_data[7:4];
    end
  end
  rst_quiet_a: assert property (disable iff (1'b0) rst |=> pwm_out == 4'h0 && rd_data == 32'h0000_0000)
    else $error("outputs not quiet after reset");
  rd_idle_a: assert property (!rd_en |=> rd_data == 32'h0000_0000)
    else $error("read data outside read cycle");
  rd_unaligned_a: assert property (rd_en && addr[1:0] != 2'h0 |=> rd_data == 32'h0000_0000)
    else $error("unaligned read not zero");
  rd_unmapped_a: assert property (rd_en && addr == 12'h014 |=> rd_data == 32'h0000_0000)
    else $error("unmapped read not zero");
  run_read_a: assert property (rd_en && addr == OFS_CTRL |=> rd_data[1:0] == $past(run_q))
    else $error("run bits do not match start and stop writes");
  stopped_low_a: assert property ((run_q == 2'h0) [*3] |-> pwm_out == 4'h0)
    else $error("pwm while no controller runs");
  unmapped_low_a: assert property ((!map0_q[0] && !map1_q[0]) [*3] |-> !pwm_out[0])
    else $error("channel without controller toggles");
  same_wave_a: assert property ((map1_q == 4'hE && map0_q[3:1] == 3'h0) [*3]
    |-> pwm_out[1] == pwm_out[2] && pwm_out[2] == pwm_out[3])
    else $error("channels of one controller differ");
  cover property (run_q == 2'h3);
  cover property ($rose(pwm_out[0]));
  cover property (rd_en && addr == OFS_POWER0);
endmodule
bind spv_top spv_top_properties #(.FB_TICK(FB_TICK)) u_props (.ref_clk(ref_clk), .rst(rst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .pwm_out(pwm_out));

/* File: tb/spv_laser_model.sv */
// laser driver model: measures period and high time of one pwm line
`timescale 1ns/100ps
module spv_laser_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pwm from the block
  input wire logic pwm,
  // last complete pulse train period
  output logic [31:0] period_cyc,
  output logic [31:0] high_cyc
);
  logic [31:0] cnt_q;
  logic [31:0] hcnt_q;
  logic pwm_q;
  // a period counts from one rising edge to the next
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= 32'h0000_0000;
      hcnt_q <= 32'h0000_0000;
      pwm_q <= 1'b0;
      period_cyc <= 32'h0000_0000;
      high_cyc <= 32'h0000_0000;
    end else begin
      pwm_q <= pwm;
      if (pwm && !pwm_q) begin
        period_cyc <= cnt_q;
        high_cyc <= hcnt_q;
        cnt_q <= 32'h0000_0001;
        hcnt_q <= 32'h0000_0001;
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
        hcnt_q <= hcnt_q + {31'h0, pwm};
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the speed-dependent pwm block
`timescale 1ns/100ps
module testbench;
  import spv_pkg::*;
  typedef struct {
    logic [1:0] ty;
    logic [31:0] fix, p0, p1;
    logic [15:0] spd;
    logic [31:0] pw, per, hi;
  } spv_row_t;
  // table 0: speed points 0 and 1000, interpolated in between
  spv_row_t rows [6] = '{
    '{2'h1, 32'h186A0, 32'h190, 32'h640, 16'h01F4, 32'h3E8, 32'h64, 32'h32},
    '{2'h1, 32'h186A0, 32'h190, 32'h640, 16'h07D0, 32'h640, 32'h64, 32'h50},
    '{2'h1, 32'h186A0, 32'h190, 32'h640, 16'hFF06, 32'h2BC, 32'h64, 32'h23},
    '{2'h1, 32'h186A0, 32'h190, 32'h640, 16'h0000, 32'h190, 32'h64, 32'h14},
    '{2'h2, 32'hBB8, 32'h186A0, 32'h30D40, 16'h01F4, 32'h249F0, 32'h42, 32'h1E},
    '{2'h3, 32'h3E8, 32'h186A0, 32'h30D40, 16'h03E8, 32'h30D40, 32'h32, 32'h19}};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = 12'h000;
  logic [DATA_W-1:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic signed [VEL_W-1:0] cmd_vel [NUM_AXIS] = '{default: 16'h0};
  logic signed [VEL_W-1:0] fb_vel [NUM_AXIS] = '{default: 16'h0};
  logic [NUM_CH-1:0] pwm_out;
  logic [31:0] per0, hi0, per2, hi2;
  int bad_count = 0;
  int checked = 0;
  always #50 ref_clk = ~ref_clk;
  spv_top #(.FB_TICK(10)) u_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .cmd_vel(cmd_vel), .fb_vel(fb_vel), .pwm_out(pwm_out));
  spv_laser_model u_las0 (.ref_clk(ref_clk), .rst(rst), .pwm(pwm_out[0]), .period_cyc(per0), .high_cyc(hi0));
  spv_laser_model u_las2 (.ref_clk(ref_clk), .rst(rst), .pwm(pwm_out[2]), .period_cyc(per2), .high_cyc(hi2));
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] msk, input logic [31:0] exp, input string m);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data & msk, exp, m);
  endtask
  // table n: mode, fixed setting, second speed point 1000, both powers
  task automatic tbl(input int n, input logic [31:0] md, input logic [31:0] fx, input logic [31:0] p0,
                     input logic [31:0] p1);
    wr(12'h100 + 12'(16 * n), md);
    wr(12'h104 + 12'(16 * n), fx);
    wr(12'h808 | 12'(n << 8), 32'h3E8);
    wr(12'h804 | 12'(n << 8), p0);
    wr(12'h80C | 12'(n << 8), p1);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(12'h100, 32'hFFFF_FFFF, 32'h101, "mode reset value");
    rdc(12'h104, 32'hFFFF_FFFF, 32'h64, "fixed reset value");
    rdc(12'h108, 32'hFFFF_FFFF, 32'h1, "source reset value");
    rdc(12'h014, 32'hFFFF_FFFF, 32'h0, "unmapped read");
    rdc(12'h102, 32'hFFFF_FFFF, 32'h0, "unaligned read");
    tbl(0, 32'h211, rows[0].fix, rows[0].p0, rows[0].p1);
    wr(OFS_CFG0, 32'h10);
    settle(300);
    chk(32'(pwm_out), 32'h0, "output before start");
    wr(OFS_CTRL, 32'h1);
    foreach (rows[i]) begin
      // rewrite only while stopped: a slow transient period would be latched at a wrap
      wr(OFS_CTRL, 32'h4);
      tbl(0, 32'h210 | 32'(rows[i].ty), rows[i].fix, rows[i].p0, rows[i].p1);
      @(posedge ref_clk);
      cmd_vel[0] <= rows[i].spd;
      settle(4);
      wr(OFS_CTRL, 32'h1);
      settle(400);
      chk(per0, rows[i].per, "period");
      chk(hi0, rows[i].hi, "high time");
      rdc(OFS_POWER0, 32'hFFFF_FFFF, rows[i].pw, "power");
    end
    // second controller on three channels from table 7, axis 1
    tbl(7, 32'h213, 32'h1F4, 32'h186A0, 32'h186A0);
    wr(12'h178, 32'h2);
    @(posedge ref_clk);
    cmd_vel[1] <= 16'h012C;
    wr(OFS_CFG1, 32'hE7);
    wr(OFS_CTRL, 32'h2);
    settle(400);
    chk(per2, 32'h64, "second period");
    chk(hi2, 32'h19, "second high time");
    rdc(OFS_CTRL, 32'h3, 32'h3, "both running");
    wr(OFS_CFG1, 32'hE0);
    settle(400);
    chk(per2, 32'h32, "period after table switch");
    wr(OFS_CTRL, 32'h4);
    settle(300);
    chk(32'(pwm_out[0]), 32'h0, "stopped channel");
    rdc(OFS_CTRL, 32'h3, 32'h2, "run state after stop");
    // filtered feedback on table 0, second controller held while the table is rewritten
    wr(OFS_CTRL, 32'h8);
    tbl(0, 32'h221, rows[0].fix, rows[0].p0, rows[0].p1);
    @(posedge ref_clk);
    fb_vel[0] <= 16'hF830;
    settle(400);
    rdc(OFS_POWER0, 32'hFFFF_FFFF, 32'h640, "filtered feedback power");
    rdc(OFS_POWER1, 32'hFFFF_FFFF, 32'h640, "second controller feedback power");
    wr(OFS_CTRL, 32'h2);
    settle(400);
    chk(per2, 32'h64, "feedback period");
    chk(hi2, 32'h50, "feedback high time");
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    print_verdict;
  end
endmodule
